// ===== adc_seq_pkg.sv
// constants, field layouts and types shared by the scan sequencer and its
// conversion engine; assumes a 32-bit AXI4-Lite register window of 256 bytes
package adc_seq_pkg;

  localparam int NUM_INPUTS = 8;
  localparam int RES_BITS   = 12;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRIG = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h08;
  localparam logic [7:0] OFF_RES0 = 8'h20;

  // control register fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_BUSY_BIT  = 10;
  localparam int CTRL_CUR_LSB   = 12;

  // flag register fields: done in [7:0], overrun in [15:8]
  localparam int FLAG_DONE_LSB = 0;
  localparam int FLAG_OVR_LSB  = 8;

  localparam logic [13:0] TRIG_RESET = 14'h0007;

  // sampling lasts sample_sel + 4 operating-clock ticks
  localparam logic [3:0] SMP_BASE = 4'h4;
  localparam logic [3:0] MSB_IDX  = 4'hB;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_SOFT  = 2'b00,
    SRC_TMR_A = 2'b01,
    SRC_TMR_B = 2'b10,
    SRC_EXT   = 2'b11
  } trig_src_t;

  // matches trigger register bits [13:0]
  typedef struct packed {
    logic [2:0] last_input_sel;
    logic [2:0] first_input_sel;
    logic       result_align_sel;
    logic       scan_repeat_sel;
    trig_src_t  trigger_source_sel;
    logic       rsvd;
    logic [2:0] sample_sel;
  } trig_cfg_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_TRIG = 3'b010,
    SEL_FLAG = 3'b011,
    SEL_RES  = 3'b100
  } reg_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ALIGN = 2'b01,
    ST_CONV  = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_CONV   = 2'b10
  } eng_phase_t;

endpackage

// ===== sar_engine.sv
// successive-approximation engine: one sampling phase, then twelve decisions
// assumes tick is a one-cycle enable at least three aclk cycles apart, so the
// synchronised comparator has settled on each new trial code
`timescale 1ns/10ps
module sar_engine
  import adc_seq_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                tick,
  input  wire logic                start,
  input  wire logic [2:0]          sample_sel,
  input  wire logic                comparator_hi,
  output logic                     done,
  output logic [RES_BITS-1:0]      result,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     sample_hold
);

  eng_phase_t          phase;
  logic [3:0]          cnt;
  logic [RES_BITS-1:0] decided;

  // keep the trial bit when the input is above the trial level
  always_comb begin
    decided = dac_code;
    if (!comparator_hi) begin
      decided[cnt] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase       <= PH_IDLE;
      cnt         <= 4'h0;
      done        <= 1'b0;
      result      <= 12'h000;
      dac_code    <= 12'h000;
      sample_hold <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (phase)
        PH_IDLE: begin
          if (start) begin
            phase       <= PH_SAMPLE;
            cnt         <= SMP_BASE + {1'b0, sample_sel} - 4'h1;
            sample_hold <= 1'b1;
            // trial code from the previous input must not show while sampling
            dac_code    <= 12'h000;
          end
        end
        PH_SAMPLE: begin
          if (tick) begin
            if (cnt == 4'h0) begin
              phase       <= PH_CONV;
              sample_hold <= 1'b0;
              cnt         <= MSB_IDX;
              dac_code    <= 12'h800;
            end else begin
              cnt <= cnt - 4'h1;
            end
          end
        end
        PH_CONV: begin
          if (tick) begin
            if (cnt == 4'h0) begin
              result <= decided;
              done   <= 1'b1;
              phase  <= PH_IDLE;
            end else begin
              dac_code          <= decided;
              dac_code[cnt-4'h1] <= 1'b1;
              cnt               <= cnt - 4'h1;
            end
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== adc_scan_trigger_sequencer.sv
// scan sequencer of a 12-bit SAR converter with an AXI4-Lite register slave
// assumes timer_derived_clk and timer_underflow are one-cycle pulses made on
// aclk; ext_trigger_in_n and comparator_hi are asynchronous pins
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module adc_scan_trigger_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_derived_clk,
  input  wire logic        timer_underflow,
  input  wire logic        ext_trigger_in_n,
  input  wire logic        comparator_hi,
  output logic [11:0]      dac_code,
  output logic             sample_hold,
  output logic [2:0]       analog_mux_sel
);

  ////////////////////////////////////////////////////////////////////////
  // decoding shared by the read and write paths

  function automatic reg_sel_t reg_decode(input logic [7:0] a);
    reg_decode = SEL_NONE;
    if (a[1:0] != 2'h0) begin
      reg_decode = SEL_NONE;
    end else if (a == OFF_CTRL) begin
      reg_decode = SEL_CTRL;
    end else if (a == OFF_TRIG) begin
      reg_decode = SEL_TRIG;
    end else if (a == OFF_FLAG) begin
      reg_decode = SEL_FLAG;
    end else if (a[7:5] == OFF_RES0[7:5]) begin
      reg_decode = SEL_RES;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  logic                en_bit;
  logic                conv_start_bit;
  trig_cfg_t           cfg;
  logic [7:0]          input_done_flag;
  logic [7:0]          input_overrun_flag;
  logic [RES_BITS-1:0] input_result_reg [NUM_INPUTS];
  seq_state_t          state;
  logic [2:0]          current_input_num;
  logic                conv_busy_flag;
  logic                sw_req;
  logic                ext_s1;
  logic                ext_s2;
  logic                ext_prev;
  logic                cmp_s1;
  logic                cmp_s2;
  logic                eng_start;
  logic                eng_done;
  logic [RES_BITS-1:0] eng_result;

  logic                aw_have;
  logic [7:0]          aw_addr;
  logic                w_have;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                wr_fire;
  reg_sel_t            wr_sel;
  logic                ext_fall;
  logic                trig_hit;
  logic                accept;
  logic                store;
  logic                keep_going;

  assign wr_fire        = aw_have && w_have && !s_axi_bvalid;
  assign wr_sel         = reg_decode(aw_addr);
  assign ext_fall       = ext_prev && !ext_s2;
  assign store          = (state == ST_CONV) && eng_done;
  assign keep_going     = conv_start_bit && en_bit;
  assign analog_mux_sel = current_input_num;

  // source select; both middle codes mean timer underflow
  always_comb begin
    unique case (cfg.trigger_source_sel)
      SRC_SOFT: trig_hit = sw_req;
      SRC_EXT:  trig_hit = ext_fall;
      default:  trig_hit = timer_underflow;
    endcase
  end

  // start bit arms pin and timer sources
  assign accept = (state == ST_IDLE) && !conv_busy_flag && en_bit
                  && conv_start_bit && trig_hit;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1   <= 1'b1;
      ext_s2   <= 1'b1;
      ext_prev <= 1'b1;
      cmp_s1   <= 1'b0;
      cmp_s2   <= 1'b0;
    end else begin
      ext_s1   <= ext_trigger_in_n;
      ext_s2   <= ext_s1;
      ext_prev <= ext_s2;
      cmp_s1   <= comparator_hi;
      cmp_s2   <= cmp_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b1;
      w_have        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have       <= 1'b0;
        w_have        <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_bit         <= 1'b0;
      conv_start_bit <= 1'b0;
      cfg            <= TRIG_RESET;
      sw_req         <= 1'b0;
    end else begin
      sw_req <= 1'b0;
      // only software changes the start bit
      if (wr_fire && (wr_sel == SEL_CTRL) && w_strb[0]) begin
        en_bit         <= w_data[CTRL_EN_BIT];
        conv_start_bit <= w_data[CTRL_START_BIT];
        // a software start needs a 0 then 1 on the start bit
        sw_req <= !conv_start_bit && w_data[CTRL_START_BIT];
      end
      if (wr_fire && (wr_sel == SEL_TRIG)) begin
        if (w_strb[0]) begin
          cfg[7:0] <= w_data[7:0];
          cfg.rsvd <= 1'b0;
        end
        if (w_strb[1]) begin
          cfg[13:8] <= w_data[13:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan sequencer

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state             <= ST_IDLE;
      current_input_num <= 3'h0;
      conv_busy_flag    <= 1'b1;
      eng_start         <= 1'b0;
    end else begin
      eng_start <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          // busy also reads one while the block is disabled
          conv_busy_flag <= !en_bit;
          if (accept) begin
            state             <= ST_ALIGN;
            current_input_num <= cfg.first_input_sel;
            conv_busy_flag    <= 1'b1;
          end
        end
        ST_ALIGN: begin
          if (timer_derived_clk) begin
            state     <= ST_CONV;
            eng_start <= 1'b1;
          end
        end
        ST_CONV: begin
          if (eng_done) begin
            if (keep_going && (current_input_num != cfg.last_input_sel)) begin
              state             <= ST_ALIGN;
              current_input_num <= current_input_num + 3'h1;
            end else if (keep_going && cfg.scan_repeat_sel) begin
              state             <= ST_ALIGN;
              current_input_num <= cfg.first_input_sel;
            end else begin
              // one-shot end or stop request once this input is stored
              state          <= ST_IDLE;
              conv_busy_flag <= !en_bit;
              if (current_input_num == 3'h7) begin
                current_input_num <= 3'h0;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  sar_engine u_engine (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .tick          (timer_derived_clk),
    .start         (eng_start),
    .sample_sel    (cfg.sample_sel),
    .comparator_hi (cmp_s2),
    .done          (eng_done),
    .result        (eng_result),
    .dac_code      (dac_code),
    .sample_hold   (sample_hold)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-input results and flags; a set in the clearing cycle wins

  genvar m;
  generate
    for (m = 0; m < NUM_INPUTS; m++) begin : g_input
      logic hit;
      logic clr_done;
      logic clr_ovr;
      assign hit      = store && (current_input_num == 3'(m));
      assign clr_done = wr_fire && (wr_sel == SEL_FLAG) && w_strb[0]
                        && w_data[FLAG_DONE_LSB+m];
      assign clr_ovr  = wr_fire && (wr_sel == SEL_FLAG) && w_strb[1]
                        && w_data[FLAG_OVR_LSB+m];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          input_result_reg[m] <= 12'h000;
        end else if (hit) begin
          input_result_reg[m] <= eng_result;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          input_done_flag[m]    <= 1'b0;
          input_overrun_flag[m] <= 1'b0;
        end else begin
          input_done_flag[m] <= hit || (input_done_flag[m] && !clr_done);
          // scanning goes on after an overrun
          input_overrun_flag[m] <= (hit && input_done_flag[m])
                                   || (input_overrun_flag[m] && !clr_ovr);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [RES_BITS-1:0] r;
    r         = input_result_reg[a[4:2]];
    read_word = 32'h00000000;
    unique case (reg_decode(a))
      SEL_CTRL: begin
        read_word[CTRL_EN_BIT]                  = en_bit;
        read_word[CTRL_START_BIT]               = conv_start_bit;
        read_word[CTRL_BUSY_BIT]                = conv_busy_flag;
        read_word[CTRL_CUR_LSB+2:CTRL_CUR_LSB]  = current_input_num;
      end
      SEL_TRIG: read_word[13:0] = cfg;
      SEL_FLAG: begin
        read_word[FLAG_DONE_LSB+7:FLAG_DONE_LSB] = input_done_flag;
        read_word[FLAG_OVR_LSB+7:FLAG_OVR_LSB]   = input_overrun_flag;
      end
      // justification applied on read, so flipping it moves all results at once
      SEL_RES: begin
        if (cfg.result_align_sel) begin
          read_word[15:0] = {r, 4'h0};
        end else begin
          read_word[15:0] = {4'h0, r};
        end
      end
      default: read_word = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_word(s_axi_araddr);
        s_axi_rresp   <= (reg_decode(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ===== adc_front_model.sv
// analog front end and timer tick source facing the sequencer
// assumes one aclk domain; vin holds the level seen on each input
`timescale 1ns/10ps
module adc_front_model
  import adc_seq_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [11:0]      dac_code,
  input  wire logic [2:0]       analog_mux_sel,
  input  wire logic [7:0][11:0] vin,
  output logic                  comparator_hi,
  output logic                  timer_derived_clk
);
  logic [1:0] tick_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 2'h0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end

  // one pulse in four cycles keeps the engine's minimum spacing of three
  assign timer_derived_clk = (tick_cnt == 2'h3);
  // level sits half a step above vin, so a tie never depends on > or >=
  assign comparator_hi = {vin[analog_mux_sel], 1'b1} > {dac_code, 1'b0};
endmodule

// ===== adc_seq_sva.sv
// port assertions for the scan sequencer
// assumes a single aclk domain with synchronous active-low reset
`timescale 1ns/10ps
module adc_seq_sva
  import adc_seq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_derived_clk,
  input wire logic [11:0] dac_code,
  input wire logic        sample_hold,
  input wire logic [2:0]  analog_mux_sel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address open while answer pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_sample_zero: assert property (sample_hold |-> dac_code == 12'h000)
    else $error("trial code not zero while sampling");
  a_sample_len: assert property ($rose(sample_hold) |-> sample_hold[*8])
    else $error("sampling phase too short");
  a_trial_msb: assert property ($fell(sample_hold) |-> ##[0:2] dac_code == 12'h800)
    else $error("conversion did not open with msb trial");
  a_mux_hold: assert property (sample_hold && $past(sample_hold) |-> $stable(analog_mux_sel))
    else $error("input changed during sampling");
  a_tick_start: assert property ($rose(sample_hold) |->
    $past(timer_derived_clk) || $past(timer_derived_clk, 2) || $past(timer_derived_clk, 3))
    else $error("sampling began off the operating clock");

  c_sample: cover property ($rose(sample_hold));
  c_conv: cover property ($fell(sample_hold));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind adc_scan_trigger_sequencer adc_seq_sva chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_derived_clk(timer_derived_clk), .dac_code(dac_code),
  .sample_hold(sample_hold), .analog_mux_sel(analog_mux_sel));

// ===== adc_scan_trigger_sequencer_tb.sv
// self-checking bench for the scan sequencer
// assumes the front end model supplies ticks and comparator decisions
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module adc_scan_trigger_sequencer_tb
  import adc_seq_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tdclk, uflow, trig_n, cmp_hi, shold;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [11:0] dac;
  logic [2:0] mux;
  logic [7:0][11:0] vin;
  int mismatches, checks_done;

  adc_scan_trigger_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_derived_clk(tdclk), .timer_underflow(uflow), .ext_trigger_in_n(trig_n),
    .comparator_hi(cmp_hi), .dac_code(dac), .sample_hold(shold), .analog_mux_sel(mux));
  adc_front_model fe (.aclk(aclk), .aresetn(aresetn), .dac_code(dac), .analog_mux_sel(mux),
    .vin(vin), .comparator_hi(cmp_hi), .timer_derived_clk(tdclk));

  always #50 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
    stop_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // polls a status bit; a scan of two inputs takes about 136 to 192 cycles, by sample_sel
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    for (int n = 0; n < 400; n++) begin
      rd(a);
      if (d[b] === v) return;
    end
    hang();
  endtask

  task automatic set_trig(input logic [1:0] src, input logic rep, al, input logic [2:0] lo, hi);
    trig_cfg_t c;
    c = '{last_input_sel: hi, first_input_sel: lo, result_align_sel: al, scan_repeat_sel: rep,
          trigger_source_sel: trig_src_t'(src), rsvd: 1'b0, sample_sel: 3'($urandom)};
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_TRIG, {18'h0, c});
    rd(OFF_TRIG);
    `CHK(d, {18'h0, c})
  endtask

  task automatic run_scan();
    wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b1);
    wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b0);
  endtask

  task automatic pulse_uflow();
    @(posedge aclk);
    uflow <= 1'b1;
    @(posedge aclk);
    uflow <= 1'b0;
  endtask

  function automatic logic [31:0] exp_res(input logic [11:0] v, input logic al);
    return al ? {16'h0, v, 4'h0} : {20'h0, v};
  endfunction

  function automatic logic [7:0] res_addr(input int m);
    return OFF_RES0 + 8'(4 * m);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, uflow} = '0;
    trig_n = 1'b1;
    {awaddr, araddr, wdata} = '0;
    void'($urandom(16));
    foreach (vin[m]) vin[m] = 12'($urandom);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL);
    `CHK(d, 32'h0000_0400)
    rd(OFF_TRIG);
    `CHK(d, {18'h0, TRIG_RESET})
    rd(8'hF0);
    `CHK(r, RESP_SLVERR)
    wr(8'hF0, 32'hFFFF_FFFF);
    `CHK(r, RESP_SLVERR)
    $display("test reset done");
    // one-shot software scan of inputs 2..4
    set_trig(2'h0, 1'b0, 1'b0, 3'h2, 3'h4);
    wr(OFF_CTRL, 32'h0000_0003);
    run_scan();
    rd(OFF_CTRL);
    `CHK(d[14:12], 3'h4)
    `CHK(d[1], 1'b1)
    rd(OFF_FLAG);
    `CHK(d, 32'h0000_001C)
    for (int m = 1; m < 6; m++) begin
      rd(res_addr(m));
      `CHK(d, (m > 1 && m < 5) ? exp_res(vin[m], 1'b0) : 32'h0)
    end
    $display("test one-shot done");
    // left alignment, then a rescan over results whose done flags were never cleared
    set_trig(2'h0, 1'b0, 1'b1, 3'h2, 3'h4);
    rd(res_addr(3));
    `CHK(d, exp_res(vin[3], 1'b1))
    for (int m = 2; m < 5; m++) vin[m] = 12'($urandom);
    wr(OFF_CTRL, 32'h0000_0003);
    run_scan();
    rd(OFF_FLAG);
    `CHK(d, 32'h0000_1C1C)
    for (int m = 2; m < 5; m++) begin
      rd(res_addr(m));
      `CHK(d, exp_res(vin[m], 1'b1))
    end
    wr(OFF_FLAG, 32'h0000_FFFF);
    rd(OFF_FLAG);
    `CHK(d, 32'h0)
    $display("test overrun done");
    // both timer encodings; a trigger during busy is dropped
    for (int s = 1; s < 3; s++) begin
      set_trig(2'(s), 1'b0, 1'b0, 3'h0, 3'h0);
      wr(OFF_CTRL, 32'h0000_0003);
      rd(OFF_CTRL);
      `CHK(d[CTRL_BUSY_BIT], 1'b0)
      pulse_uflow();
      wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b1);
      pulse_uflow();
      wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b0);
      rd(OFF_FLAG);
      `CHK(d, 32'h0000_0001)
      pulse_uflow();
      run_scan();
      rd(OFF_FLAG);
      `CHK(d, 32'h0000_0101)
      wr(OFF_FLAG, 32'h0000_FFFF);
    end
    rd(res_addr(0));
    `CHK(d, exp_res(vin[0], 1'b0))
    $display("test timer done");
    // external pin falling edge
    set_trig(2'h3, 1'b0, 1'b0, 3'h5, 3'h5);
    wr(OFF_CTRL, 32'h0000_0003);
    rd(OFF_CTRL);
    `CHK(d[CTRL_BUSY_BIT], 1'b0)
    trig_n <= 1'b0;
    wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b1);
    trig_n <= 1'b1;
    wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b0);
    rd(res_addr(5));
    `CHK(d, exp_res(vin[5], 1'b0))
    $display("test pin done");
    // repeat mode keeps scanning until start is cleared
    wr(OFF_FLAG, 32'h0000_FFFF);
    set_trig(2'h0, 1'b1, 1'b0, 3'h6, 3'h7);
    wr(OFF_CTRL, 32'h0000_0003);
    wait_bit(OFF_FLAG, FLAG_OVR_LSB + 7, 1'b1);
    rd(OFF_CTRL);
    `CHK(d[CTRL_BUSY_BIT], 1'b1)
    wr(OFF_CTRL, 32'h0000_0001);
    wait_bit(OFF_CTRL, CTRL_BUSY_BIT, 1'b0);
    rd(res_addr(7));
    `CHK(d, exp_res(vin[7], 1'b0))
    $display("test repeat done");
    stop_test();
  end
endmodule
